//--- verilog/error_status_flag_unit.sv
`timescale 1ns/10ps
`default_nettype none
module error_status_flag_unit #(
  parameter int CODE_W = err_flag_pkg::CODE_W,
  parameter int SLOT_W = err_flag_pkg::SLOT_W,
  parameter int ADDR_W = err_flag_pkg::ADDR_W
) (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              scan_start,
  input  wire logic              init_req,
  input  wire logic              self_diag_fault,
  input  wire logic [CODE_W-1:0] self_diag_code,
  input  wire logic              io_unit_fault,
  input  wire logic [SLOT_W-1:0] io_unit_slot_low,
  input  wire logic [SLOT_W-1:0] io_unit_slot_high,
  input  wire logic              intel_unit_fault,
  input  wire logic [SLOT_W-1:0] intel_unit_slot_low,
  input  wire logic [SLOT_W-1:0] intel_unit_slot_high,
  input  wire logic              io_verify_mismatch,
  input  wire logic [SLOT_W-1:0] verify_slot_low,
  input  wire logic [SLOT_W-1:0] verify_slot_high,
  input  wire logic              battery_fault,
  input  wire logic              op_error,
  input  wire logic [ADDR_W-1:0] op_error_address,
  output logic                   self_diag_error_flag,
  output logic [CODE_W-1:0]      self_diag_code_word,
  output logic                   unused_flag_slot,
  output logic                   io_unit_error_flag,
  output logic [SLOT_W-1:0]      io_error_slot_low,
  output logic [SLOT_W-1:0]      io_error_slot_high,
  output logic                   intelligent_unit_error_flag,
  output logic [SLOT_W-1:0]      intel_error_slot_low,
  output logic [SLOT_W-1:0]      intel_error_slot_high,
  output logic                   io_verify_error_flag,
  output logic [SLOT_W-1:0]      verify_error_slot_low,
  output logic [SLOT_W-1:0]      verify_error_slot_high,
  output logic                   battery_error_pulse_flag,
  output logic                   battery_error_latch_flag,
  output logic                   op_error_latch_flag,
  output logic [ADDR_W-1:0]      first_op_error_address,
  output logic                   op_error_pulse_flag,
  output logic [ADDR_W-1:0]      latest_op_error_address
);
  // fault inputs arrive from outside the clock domain
  localparam int SYNC_N     = 6;
  localparam int SLOT_WORDS = 6;
  localparam int DATA_W     = CODE_W + SLOT_WORDS * SLOT_W + ADDR_W;
  logic [SYNC_N-1:0] sync_a;
  logic [SYNC_N-1:0] sync_b;
  logic [SYNC_N-1:0] raw_in;
  logic [SYNC_N-1:0] sync_prev;
  logic [SYNC_N-1:0] rise;
  logic              init_a;
  logic              init_b;
  logic              init_prev;
  logic              init_rise;
  logic [DATA_W-1:0] data_raw;
  logic [DATA_W-1:0] data_a;
  logic [DATA_W-1:0] data_b;
  logic [CODE_W-1:0] code_s;
  logic [SLOT_W-1:0] io_low_s;
  logic [SLOT_W-1:0] io_high_s;
  logic [SLOT_W-1:0] intel_low_s;
  logic [SLOT_W-1:0] intel_high_s;
  logic [SLOT_W-1:0] verify_low_s;
  logic [SLOT_W-1:0] verify_high_s;
  logic [ADDR_W-1:0] addr_s;

  assign raw_in = {op_error, battery_fault, io_verify_mismatch,
                   intel_unit_fault, io_unit_fault, self_diag_fault};

  // data words take the same two stages so they line up with the event
  assign data_raw = {op_error_address, verify_slot_high, verify_slot_low,
                     intel_unit_slot_high, intel_unit_slot_low,
                     io_unit_slot_high, io_unit_slot_low, self_diag_code};

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      data_a <= '0;
      data_b <= '0;
    end else begin
      data_a <= data_raw;
      data_b <= data_a;
    end
  end

  assign {addr_s, verify_high_s, verify_low_s, intel_high_s, intel_low_s,
          io_high_s, io_low_s, code_s} = data_b;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sync_a    <= '0;
      sync_b    <= '0;
      sync_prev <= '0;
      init_a    <= 1'b0;
      init_b    <= 1'b0;
      init_prev <= 1'b0;
    end else begin
      sync_a    <= raw_in;
      sync_b    <= sync_a;
      sync_prev <= sync_b;
      init_a    <= init_req;
      init_b    <= init_a;
      init_prev <= init_b;
    end
  end

  assign rise      = sync_b & ~sync_prev;
  assign init_rise = init_b & ~init_prev;

  logic self_ev;
  logic io_ev;
  logic intel_ev;
  logic verify_ev;
  logic batt_ev;
  logic op_ev;
  assign self_ev   = rise[0];
  assign io_ev     = rise[1];
  assign intel_ev  = rise[2];
  assign verify_ev = rise[3];
  assign batt_ev   = rise[4];
  assign op_ev     = rise[5];

  // level flags follow the synchronised fault condition
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      self_diag_error_flag        <= err_flag_pkg::FLAG_OFF;
      io_unit_error_flag          <= err_flag_pkg::FLAG_OFF;
      intelligent_unit_error_flag <= err_flag_pkg::FLAG_OFF;
      io_verify_error_flag        <= err_flag_pkg::FLAG_OFF;
    end else begin
      self_diag_error_flag        <= sync_b[0];
      io_unit_error_flag          <= sync_b[1];
      intelligent_unit_error_flag <= sync_b[2];
      io_verify_error_flag        <= sync_b[3];
    end
  end

  // data words are sampled with the event; sources hold them steady
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      self_diag_code_word <= CODE_W'(err_flag_pkg::WORD_ZERO);
    end else if (self_ev) begin
      self_diag_code_word <= code_s;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      io_error_slot_low  <= SLOT_W'(err_flag_pkg::WORD_ZERO);
      io_error_slot_high <= SLOT_W'(err_flag_pkg::WORD_ZERO);
    end else if (io_ev) begin
      io_error_slot_low  <= io_low_s;
      io_error_slot_high <= io_high_s;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      intel_error_slot_low  <= SLOT_W'(err_flag_pkg::WORD_ZERO);
      intel_error_slot_high <= SLOT_W'(err_flag_pkg::WORD_ZERO);
    end else if (intel_ev) begin
      intel_error_slot_low  <= intel_low_s;
      intel_error_slot_high <= intel_high_s;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      verify_error_slot_low  <= SLOT_W'(err_flag_pkg::WORD_ZERO);
      verify_error_slot_high <= SLOT_W'(err_flag_pkg::WORD_ZERO);
    end else if (verify_ev) begin
      verify_error_slot_low  <= verify_low_s;
      verify_error_slot_high <= verify_high_s;
    end
  end

  // battery hold flag: set wins over an init in the same cycle
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      battery_error_latch_flag <= err_flag_pkg::FLAG_OFF;
    end else if (batt_ev) begin
      battery_error_latch_flag <= err_flag_pkg::FLAG_ON;
    end else if (init_rise && !sync_b[4]) begin
      battery_error_latch_flag <= err_flag_pkg::FLAG_OFF;
    end
  end

  // operation error hold flag and first address
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      op_error_latch_flag    <= err_flag_pkg::FLAG_OFF;
      first_op_error_address <= ADDR_W'(err_flag_pkg::WORD_ZERO);
    end else if (op_ev) begin
      op_error_latch_flag <= err_flag_pkg::FLAG_ON;
      if (!op_error_latch_flag) begin
        first_op_error_address <= addr_s;
      end
    end else if (init_rise) begin
      op_error_latch_flag <= err_flag_pkg::FLAG_OFF;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      latest_op_error_address <= ADDR_W'(err_flag_pkg::WORD_ZERO);
    end else if (op_ev) begin
      latest_op_error_address <= addr_s;
    end
  end

  // one-scan pulse flags
  scan_pulse u_batt_pulse (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .event_in   (batt_ev),
    .scan_start (scan_start),
    .pulse      (battery_error_pulse_flag)
  );

  scan_pulse u_op_pulse (
    .mclk       (mclk),
    .arst_n     (arst_n),
    .event_in   (op_ev),
    .scan_start (scan_start),
    .pulse      (op_error_pulse_flag)
  );

  assign unused_flag_slot = err_flag_pkg::FLAG_OFF;
endmodule
`default_nettype wire

//--- include/err_flag_pkg.sv
`default_nettype none
package err_flag_pkg;
  // data word width of the captured words
  localparam int WORD_W      = 16;
  localparam int CODE_W      = 16;
  localparam int SLOT_W      = 16;
  localparam int ADDR_W      = 16;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic        FLAG_OFF  = 1'b0;
  localparam logic        FLAG_ON   = 1'b1;
  // flag bit positions inside the packed flag word
  localparam int POS_SELF_DIAG  = 0;
  localparam int POS_UNUSED     = 1;
  localparam int POS_IO_UNIT    = 2;
  localparam int POS_INTEL      = 3;
  localparam int POS_IO_VERIFY  = 4;
  localparam int POS_BATT_PULSE = 5;
  localparam int POS_BATT_LATCH = 6;
  localparam int POS_OP_LATCH   = 7;
  localparam int POS_OP_PULSE   = 8;
  localparam int FLAG_COUNT     = 9;
endpackage
`default_nettype wire

//--- verilog/scan_pulse.sv
`timescale 1ns/10ps
`default_nettype none
// holds an event until the next scan boundary, then shows it for one scan
module scan_pulse (
  input  wire logic mclk,
  input  wire logic arst_n,
  input  wire logic event_in,
  input  wire logic scan_start,
  output logic      pulse
);
  logic pending;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pending <= err_flag_pkg::FLAG_OFF;
    end else if (scan_start) begin
      pending <= event_in;
    end else if (event_in) begin
      pending <= err_flag_pkg::FLAG_ON;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pulse <= err_flag_pkg::FLAG_OFF;
    end else if (scan_start) begin
      pulse <= pending;
    end
  end
endmodule
`default_nettype wire

//--- verif/error_status_flag_checker.sv
`timescale 1ns/10ps
`default_nettype none
module error_status_flag_checker #(
  parameter int CODE_W = 16,
  parameter int ADDR_W = 16
) (
  input wire logic              mclk,
  input wire logic              arst_n,
  input wire logic              scan_start,
  input wire logic              init_req,
  input wire logic              self_diag_fault,
  input wire logic [CODE_W-1:0] self_diag_code,
  input wire logic              battery_fault,
  input wire logic              op_error,
  input wire logic [ADDR_W-1:0] op_error_address,
  input wire logic              self_diag_error_flag,
  input wire logic [CODE_W-1:0] self_diag_code_word,
  input wire logic              unused_flag_slot,
  input wire logic              battery_error_pulse_flag,
  input wire logic              battery_error_latch_flag,
  input wire logic              op_error_latch_flag,
  input wire logic [ADDR_W-1:0] first_op_error_address,
  input wire logic              op_error_pulse_flag,
  input wire logic [ADDR_W-1:0] latest_op_error_address
);
  logic [2:0] init_quiet;
  // cycles since init request was last high
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) init_quiet <= 3'h0;
    else if (init_req) init_quiet <= 3'h0;
    else if (init_quiet != 3'h7) init_quiet <= init_quiet + 3'h1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  sequence op_rise_s; $rose(op_error); endsequence
  sequence diag_rise_s; $rose(self_diag_fault); endsequence
  chk_unused_zero: assert property (unused_flag_slot == 1'b0)
    else $error("unused flag set");
  chk_diag_flag_rise: assert property (diag_rise_s |-> ##[1:4] self_diag_error_flag)
    else $error("diag flag late");
  chk_diag_code_cap: assert property (diag_rise_s |-> ##4 self_diag_code_word == $past(self_diag_code, 4))
    else $error("diag code not captured");
  chk_batt_latch_set: assert property ($rose(battery_fault) |-> ##[1:5] battery_error_latch_flag)
    else $error("battery latch late");
  chk_batt_latch_hold: assert property (battery_error_latch_flag && init_quiet >= 3'h5 |=> battery_error_latch_flag)
    else $error("battery latch dropped");
  chk_op_latch_set: assert property (op_rise_s |-> ##[1:5] op_error_latch_flag)
    else $error("op latch late");
  chk_first_addr_keep: assert property (op_error_latch_flag && $past(op_error_latch_flag) |-> $stable(first_op_error_address))
    else $error("first address rewritten");
  chk_latest_addr_cap: assert property (op_rise_s |-> ##4 latest_op_error_address == $past(op_error_address, 4))
    else $error("latest address wrong");
  chk_op_pulse_scan: assert property ($changed(op_error_pulse_flag) |-> $past(scan_start))
    else $error("op pulse off scan");
  chk_batt_pulse_scan: assert property ($changed(battery_error_pulse_flag) |-> $past(scan_start))
    else $error("battery pulse off scan");
endmodule
bind error_status_flag_unit error_status_flag_checker #(.CODE_W(CODE_W), .ADDR_W(ADDR_W)) chk_u (
  .mclk(mclk), .arst_n(arst_n), .scan_start(scan_start), .init_req(init_req),
  .self_diag_fault(self_diag_fault), .self_diag_code(self_diag_code),
  .battery_fault(battery_fault), .op_error(op_error), .op_error_address(op_error_address),
  .self_diag_error_flag(self_diag_error_flag), .self_diag_code_word(self_diag_code_word),
  .unused_flag_slot(unused_flag_slot), .battery_error_pulse_flag(battery_error_pulse_flag),
  .battery_error_latch_flag(battery_error_latch_flag), .op_error_latch_flag(op_error_latch_flag),
  .first_op_error_address(first_op_error_address), .op_error_pulse_flag(op_error_pulse_flag),
  .latest_op_error_address(latest_op_error_address));
`default_nettype wire

//--- verif/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic mclk, arst_n, scan_start, init_req, diag, iof, intf, ver, batt, ope;
  logic [15:0] code, sl[6], addr, w[9], flg;
  logic p0, p1, p2, p3, p4, p5, p6, p7, p8;
  int error_cnt, comparisons, cyc;
  assign flg = {7'h00, p8, p7, p6, p5, p4, p3, p2, p1, p0};
  error_status_flag_unit dut_u (.mclk(mclk), .arst_n(arst_n), .scan_start(scan_start),
    .init_req(init_req), .self_diag_fault(diag), .self_diag_code(code), .io_unit_fault(iof),
    .io_unit_slot_low(sl[0]), .io_unit_slot_high(sl[1]), .intel_unit_fault(intf),
    .intel_unit_slot_low(sl[2]), .intel_unit_slot_high(sl[3]), .io_verify_mismatch(ver),
    .verify_slot_low(sl[4]), .verify_slot_high(sl[5]), .battery_fault(batt), .op_error(ope),
    .op_error_address(addr), .self_diag_error_flag(p0), .self_diag_code_word(w[0]),
    .unused_flag_slot(p1), .io_unit_error_flag(p2), .io_error_slot_low(w[1]),
    .io_error_slot_high(w[2]), .intelligent_unit_error_flag(p3), .intel_error_slot_low(w[3]),
    .intel_error_slot_high(w[4]), .io_verify_error_flag(p4), .verify_error_slot_low(w[5]),
    .verify_error_slot_high(w[6]), .battery_error_pulse_flag(p5), .battery_error_latch_flag(p6),
    .op_error_latch_flag(p7), .first_op_error_address(w[7]), .op_error_pulse_flag(p8),
    .latest_op_error_address(w[8]));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic scan();
    scan_start = 1'b1;
    tick(1);
    scan_start = 1'b0;
    tick(3);
  endtask
  task automatic init_pulse();
    init_req = 1'b1;
    tick(5);
    init_req = 1'b0;
    tick(5);
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc > 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    {arst_n, scan_start, init_req, diag, iof, intf, ver, batt, ope} = 9'h000;
    code = 16'h0000;
    addr = 16'h0000;
    foreach (sl[i]) sl[i] = 16'h0000;
    tick(10);
    arst_n = 1'b1;
    tick(1);
    chk("flags", 16'h0000, flg);
    foreach (w[i]) chk("word", 16'h0000, w[i]);
    code = 16'hC0DE;
    foreach (sl[i]) sl[i] = 16'hA0 + 16'(i);
    {diag, iof, intf, ver} = 4'hF;
    tick(5);
    chk("flags", 16'h001D, flg);
    chk("code", 16'hC0DE, w[0]);
    for (int i = 0; i < 6; i++) chk("slot", 16'hA0 + 16'(i), w[i+1]);
    {diag, iof, intf, ver} = 4'h0;
    tick(5);
    chk("flags", 16'h0000, flg);
    batt = 1'b1;
    tick(5);
    chk("flags", 16'h0040, flg);
    scan();
    chk("flags", 16'h0060, flg);
    scan();
    chk("flags", 16'h0040, flg);
    init_pulse();
    chk("flags", 16'h0040, flg);
    batt = 1'b0;
    init_pulse();
    chk("flags", 16'h0000, flg);
    addr = 16'h1234; ope = 1'b1;
    tick(5);
    ope = 1'b0;
    tick(2);
    addr = 16'h5678; ope = 1'b1;
    tick(5);
    chk("flags", 16'h0080, flg);
    chk("first", 16'h1234, w[7]);
    chk("latest", 16'h5678, w[8]);
    scan();
    chk("flags", 16'h0180, flg);
    scan();
    chk("flags", 16'h0080, flg);
    arst_n = 1'b0;
    tick(2);
    arst_n = 1'b1;
    tick(1);
    chk("flags", 16'h0000, flg);
    chk("first", 16'h0000, w[7]);
    end_of_test();
  end
endmodule
`default_nettype wire
